//--- src/sep_pkg.sv
// Shared constants for the serial EEPROM link: opcodes, status layout,
// ECC geometry, write-cycle timing and the host controller register map.
// Assumes a 25 MHz system clock on both ends.
package sep_pkg;

  // ==========================================================================
  // Array and ECC geometry
  localparam int ADDR_W      = 15;
  localparam int DATA_W      = 32;
  localparam int CHECK_W     = 6;
  localparam int CODE_W      = DATA_W + CHECK_W;
  localparam logic [31:0] ERASED_WORD = 32'hFFFF_FFFF;

  // ==========================================================================
  // Instruction codes
  localparam logic [7:0] OP_WREN  = 8'h06;
  localparam logic [7:0] OP_WRDI  = 8'h04;
  localparam logic [7:0] OP_RDSR  = 8'h05;
  localparam logic [7:0] OP_WRSR  = 8'h01;
  localparam logic [7:0] OP_READ  = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;

  // ==========================================================================
  // Status byte fields
  localparam int SR_LOCK   = 7;
  localparam int SR_BP_HI  = 3;
  localparam int SR_BP_LO  = 2;
  localparam int SR_WEL    = 1;
  localparam int SR_BUSY   = 0;

  // ==========================================================================
  // Bit and byte counting
  localparam logic [2:0] BIT_LAST  = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BYTE_MAX  = 3'h7;
  localparam logic [2:0] BYTES_1   = 3'h1;
  localparam logic [2:0] BYTES_2   = 3'h2;
  // Pin sync reset levels {cs_n, sck, si, hold_n, wp_n}
  localparam logic [4:0] PIN_IDLE  = 5'h13;

  // ==========================================================================
  // Timing
  localparam real PROG_TIME_MS  = 5.0;
  localparam int  CLK_FREQ_HZ   = 25_000_000;
  localparam int  PROG_CYCLES   =
    $rtoi(PROG_TIME_MS * CLK_FREQ_HZ / 1000.0);
  localparam int  SCK_HALF      = 4;

  // ==========================================================================
  // Host controller registers (byte addresses)
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_DATA   = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam int CTRL_SEL   = 0;
  localparam int CTRL_PAUSE = 1;
  localparam int CTRL_WP    = 2;
  localparam int CTRL_CPOL  = 3;
  localparam int CTRL_W     = 4;
  localparam int STAT_BUSY  = 0;

  // ==========================================================================
  // Device serial states
  typedef enum logic [8:0] {
    ST_IDLE  = 9'h001,
    ST_CMD   = 9'h002,
    ST_ADDR  = 9'h004,
    ST_RDSR  = 9'h008,
    ST_WRSR  = 9'h010,
    ST_READ  = 9'h020,
    ST_WRITE = 9'h040,
    ST_DONE  = 9'h080,
    ST_DEAD  = 9'h100
  } sep_state_type;

endpackage : sep_pkg

//--- src/sep_spi_if.sv
// Serial link between host controller and EEPROM device.
// so carries device data only while so_oe is high.
`timescale 1ns/100ps
`default_nettype none
interface sep_spi_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so;
  logic so_oe;
  logic hold_n;
  logic wp_n;

  modport host (
    output cs_n, sck, si, hold_n, wp_n,
    input  so, so_oe
  );
  modport dev (
    input  cs_n, sck, si, hold_n, wp_n,
    output so, so_oe
  );
endinterface : sep_spi_if
`default_nettype wire

//--- src/sep_device.sv
// EEPROM device end: pin front end, instruction handling, ECC array and
// self-timed write cycle. Pins are asynchronous to clk_i and synchronised.
//
// Chosen here: the address map and the four-byte ECC group layout.
`timescale 1ns/100ps
`default_nettype none
module sep_device #(
  parameter int ADDR_W      = sep_pkg::ADDR_W,     // Byte address width
  parameter int PROG_CYCLES = sep_pkg::PROG_CYCLES // Write cycle length
) (
  input  wire logic clk_i,   // System clock
  input  wire logic rst_i,   // Sync reset, high
  sep_spi_if.dev    spi,     // Serial link
  output logic      busy_o   // Write cycle running
);

  localparam int DW    = sep_pkg::DATA_W;
  localparam int CW    = sep_pkg::CHECK_W;
  localparam int NW    = sep_pkg::CODE_W;
  localparam int GRP_W = ADDR_W - 2;
  localparam int GROUPS = 2 ** GRP_W;

  // ==========================================================================
  // ECC helpers
  function automatic logic [NW-1:0] ecc_make(input logic [DW-1:0] d);
    logic [NW-1:0] c;
    logic [CW-1:0] s;
    int            j;
    c = '0;
    s = '0;
    j = 0;
    for (int p = 1; p <= NW; p++) begin
      if ((p & (p - 1)) != 0) begin
        c[p-1] = d[j];
        j++;
      end
    end
    for (int p = 1; p <= NW; p++) begin
      if (c[p-1]) begin
        s = s ^ CW'(p);
      end
    end
    for (int k = 0; k < CW; k++) begin
      c[(1 << k) - 1] = s[k];
    end
    return c;
  endfunction : ecc_make

  function automatic logic [DW-1:0] ecc_fix(input logic [NW-1:0] w);
    logic [NW-1:0] c;
    logic [CW-1:0] s;
    logic [DW-1:0] d;
    int            j;
    c = w;
    s = '0;
    d = '0;
    j = 0;
    for (int p = 1; p <= NW; p++) begin
      if (c[p-1]) begin
        s = s ^ CW'(p);
      end
    end
    if (s != '0 && int'(s) <= NW) begin
      c[int'(s) - 1] = ~c[int'(s) - 1];
    end
    for (int p = 1; p <= NW; p++) begin
      if ((p & (p - 1)) != 0) begin
        d[j] = c[p-1];
        j++;
      end
    end
    return d;
  endfunction : ecc_fix

  // ==========================================================================
  // Pin synchronisers
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  logic       sck_q_reg;
  logic       cs_q_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_reg <= sep_pkg::PIN_IDLE;
      sync2_reg <= sep_pkg::PIN_IDLE;
      sck_q_reg <= 1'b0;
      cs_q_reg  <= 1'b1;
    end else begin
      sync1_reg <= {spi.cs_n, spi.sck, spi.si, spi.hold_n, spi.wp_n};
      sync2_reg <= sync1_reg;
      sck_q_reg <= sync2_reg[3];
      cs_q_reg  <= sync2_reg[4];
    end
  end

  logic cs_s, sck_s, si_s, hold_s, wp_s;
  logic go, sck_rise, sck_fall, cs_rise;
  assign cs_s   = sync2_reg[4];
  assign sck_s  = sync2_reg[3];
  assign si_s   = sync2_reg[2];
  assign hold_s = sync2_reg[1];
  assign wp_s   = sync2_reg[0];
  assign go       = ~cs_s & hold_s;
  assign sck_rise = go & sck_s & ~sck_q_reg;
  assign sck_fall = go & ~sck_s & sck_q_reg;
  assign cs_rise  = cs_s & ~cs_q_reg;

  // ==========================================================================
  // Serial state
  sep_pkg::sep_state_type state_reg;
  logic [7:0]        sh_reg, op_reg, tx_reg, addr_hi_reg, sr_new_reg;
  logic [2:0]        bit_reg, byte_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [DW-1:0]     wbuf_reg;
  logic              dirty_reg, out_en_reg, so_reg;
  logic              busy_reg, wel_reg, lock_reg;
  logic [1:0]        bp_reg;

  logic [7:0]        rx_byte, rd_byte, status_byte;
  logic [ADDR_W-1:0] addr_full, rd_addr;
  logic [DW-1:0]     rd_group;
  logic              byte_done;
  logic [NW-1:0]     mem [0:GROUPS-1];

  assign rx_byte   = {sh_reg[6:0], si_s};
  assign byte_done = sck_rise & (bit_reg == sep_pkg::BIT_LAST);
  assign addr_full = {addr_hi_reg[ADDR_W-9:0], rx_byte};
  assign rd_addr   = (state_reg == sep_pkg::ST_ADDR) ? addr_full : addr_reg;
  assign rd_group  = ecc_fix(mem[rd_addr[ADDR_W-1:2]]);
  assign rd_byte   = rd_group[{rd_addr[1:0], 3'h0} +: 8];

  always_comb begin
    status_byte                   = 8'h00;
    status_byte[sep_pkg::SR_LOCK]  = lock_reg;
    status_byte[sep_pkg::SR_BP_HI] = bp_reg[1];
    status_byte[sep_pkg::SR_BP_LO] = bp_reg[0];
    status_byte[sep_pkg::SR_WEL]   = wel_reg;
    status_byte[sep_pkg::SR_BUSY]  = busy_reg;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || cs_s) begin
      state_reg  <= sep_pkg::ST_IDLE;
      bit_reg    <= sep_pkg::BIT_FIRST;
      byte_reg   <= 3'h0;
      out_en_reg <= 1'b0;
      dirty_reg  <= 1'b0;
    end else if (state_reg == sep_pkg::ST_IDLE) begin
      state_reg <= sep_pkg::ST_CMD;
    end else if (sck_rise) begin
      sh_reg  <= rx_byte;
      bit_reg <= bit_reg + 3'h1;
      if (byte_done && byte_reg != sep_pkg::BYTE_MAX) begin
        byte_reg <= byte_reg + 3'h1;
      end
      if (byte_done) begin
        unique case (state_reg)
          sep_pkg::ST_CMD: begin
            op_reg <= rx_byte;
            if (busy_reg && rx_byte != sep_pkg::OP_RDSR) begin
              state_reg <= sep_pkg::ST_DEAD;
            end else begin
              unique case (rx_byte)
                sep_pkg::OP_WREN, sep_pkg::OP_WRDI:
                  state_reg <= sep_pkg::ST_DONE;
                sep_pkg::OP_RDSR: begin
                  state_reg  <= sep_pkg::ST_RDSR;
                  tx_reg     <= status_byte;
                  out_en_reg <= 1'b1;
                end
                sep_pkg::OP_WRSR: state_reg <= sep_pkg::ST_WRSR;
                sep_pkg::OP_READ, sep_pkg::OP_WRITE:
                  state_reg <= sep_pkg::ST_ADDR;
                default: state_reg <= sep_pkg::ST_DEAD;
              endcase
            end
          end
          sep_pkg::ST_ADDR: begin
            if (byte_reg == sep_pkg::BYTES_1) begin
              addr_hi_reg <= rx_byte;
            end else if (op_reg == sep_pkg::OP_READ) begin
              state_reg  <= sep_pkg::ST_READ;
              tx_reg     <= rd_byte;
              addr_reg   <= addr_full + ADDR_W'(1);
              out_en_reg <= 1'b1;
            end else begin
              state_reg <= sep_pkg::ST_WRITE;
              wbuf_reg  <= rd_group;
              addr_reg  <= addr_full;
            end
          end
          sep_pkg::ST_READ: begin
            tx_reg   <= rd_byte;
            addr_reg <= addr_reg + ADDR_W'(1);
          end
          sep_pkg::ST_RDSR: tx_reg <= status_byte;
          sep_pkg::ST_WRSR: begin
            sr_new_reg <= rx_byte;
            state_reg  <= sep_pkg::ST_DONE;
          end
          sep_pkg::ST_WRITE: begin
            wbuf_reg[{addr_reg[1:0], 3'h0} +: 8] <= rx_byte;
            addr_reg[1:0] <= addr_reg[1:0] + 2'h1;
            dirty_reg     <= 1'b1;
          end
          sep_pkg::ST_IDLE, sep_pkg::ST_DONE, sep_pkg::ST_DEAD: begin
          end
        endcase
      end
    end
  end

  // Output shifter, moves only on falling edges
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      so_reg <= 1'b0;
    end else if (sck_fall && out_en_reg) begin
      so_reg <= tx_reg[sep_pkg::BIT_LAST - bit_reg];
    end
  end

  assign spi.so    = so_reg;
  assign spi.so_oe = go & out_en_reg;

  // ==========================================================================
  // Write cycle engine
  logic              wren_ok, wrdi_ok, wrsr_ok, write_ok, done_now;
  logic [31:0]       timer_reg;
  logic              pend_mem_reg, pend_sr_reg;
  logic [GRP_W-1:0]  pend_idx_reg;
  logic [DW-1:0]     pend_word_reg;

  assign wren_ok  = cs_rise && state_reg == sep_pkg::ST_DONE &&
                    op_reg == sep_pkg::OP_WREN &&
                    byte_reg == sep_pkg::BYTES_1 &&
                    bit_reg == sep_pkg::BIT_FIRST;
  assign wrdi_ok  = cs_rise && state_reg == sep_pkg::ST_DONE &&
                    op_reg == sep_pkg::OP_WRDI &&
                    byte_reg == sep_pkg::BYTES_1 &&
                    bit_reg == sep_pkg::BIT_FIRST;
  assign wrsr_ok  = cs_rise && state_reg == sep_pkg::ST_DONE &&
                    op_reg == sep_pkg::OP_WRSR &&
                    byte_reg == sep_pkg::BYTES_2 &&
                    bit_reg == sep_pkg::BIT_FIRST &&
                    wel_reg && !(lock_reg && !wp_s);
  assign write_ok = cs_rise && state_reg == sep_pkg::ST_WRITE &&
                    dirty_reg && bit_reg == sep_pkg::BIT_FIRST && wel_reg;
  assign done_now = busy_reg && timer_reg == 32'(PROG_CYCLES - 1);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_reg      <= 1'b0;
      timer_reg     <= 32'h0000_0000;
      wel_reg       <= 1'b0;
      lock_reg      <= 1'b0;
      bp_reg        <= 2'h0;
      pend_mem_reg  <= 1'b0;
      pend_sr_reg   <= 1'b0;
      pend_idx_reg  <= '0;
      pend_word_reg <= '0;
    end else begin
      if (wren_ok) begin
        wel_reg <= 1'b1;
      end
      if (wrdi_ok) begin
        wel_reg <= 1'b0;
      end
      if (write_ok || wrsr_ok) begin
        busy_reg      <= 1'b1;
        timer_reg     <= 32'h0000_0000;
        pend_mem_reg  <= write_ok;
        pend_sr_reg   <= wrsr_ok;
        pend_idx_reg  <= addr_reg[ADDR_W-1:2];
        pend_word_reg <= wbuf_reg;
      end else if (done_now) begin
        busy_reg     <= 1'b0;
        wel_reg      <= 1'b0;
        pend_mem_reg <= 1'b0;
        pend_sr_reg  <= 1'b0;
        if (pend_sr_reg) begin
          lock_reg <= sr_new_reg[sep_pkg::SR_LOCK];
          bp_reg   <= {sr_new_reg[sep_pkg::SR_BP_HI],
                       sr_new_reg[sep_pkg::SR_BP_LO]};
        end
      end else if (busy_reg) begin
        timer_reg <= timer_reg + 32'h0000_0001;
      end
    end
  end

  // Array with check bits per four-byte group
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int g = 0; g < GROUPS; g++) begin
        mem[g] <= ecc_make(sep_pkg::ERASED_WORD);
      end
    end else if (done_now && pend_mem_reg) begin
      mem[pend_idx_reg] <= ecc_make(pend_word_reg);
    end
  end

  assign busy_o = busy_reg;

endmodule : sep_device
`default_nettype wire

//--- src/sep_host.sv
// Host controller end: Wishbone register slave driving the serial link.
// Assumes a classic Wishbone master on clk_i; so from the device is async.
`timescale 1ns/100ps
`default_nettype none
module sep_host #(
  parameter int SCK_HALF = sep_pkg::SCK_HALF  // Clocks per sck half period
) (
  input  wire logic        clk_i,      // System clock
  input  wire logic        rst_i,      // Sync reset, high
  input  wire logic        wb_cyc_i,   // Bus cycle
  input  wire logic        wb_stb_i,   // Strobe
  input  wire logic        wb_we_i,    // Write enable
  input  wire logic [7:0]  wb_adr_i,   // Byte address
  input  wire logic [3:0]  wb_sel_i,   // Byte lanes
  input  wire logic [31:0] wb_dat_i,   // Write data
  output logic      [31:0] wb_dat_o,   // Read data
  output logic             wb_ack_o,   // Acknowledge
  sep_spi_if.host          spi         // Serial link
);

  localparam int CNT_W = $clog2(SCK_HALF + 1);

  // ==========================================================================
  // Register slave
  logic [sep_pkg::CTRL_W-1:0] ctrl_reg;
  logic [7:0]  rx_reg, tx_sh_reg;
  logic        ack_reg, xbusy_reg, sck_reg, si_reg, hi_reg;
  logic [2:0]  bitn_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic        so_s1_reg, so_s2_reg;
  logic        req, start, pause_wr;

  assign req   = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign start = req & wb_we_i & wb_sel_i[0] &
                 (wb_adr_i == sep_pkg::REG_DATA) & ~xbusy_reg &
                 ctrl_reg[sep_pkg::CTRL_SEL] &
                 ~ctrl_reg[sep_pkg::CTRL_PAUSE];
  // Freeze with hold_n so no sck edge races the pause
  assign pause_wr = req & wb_we_i & wb_sel_i[0] &
                    (wb_adr_i == sep_pkg::REG_CTRL) &
                    wb_dat_i[sep_pkg::CTRL_PAUSE];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg  <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ctrl_reg <= '0;
    end else begin
      ack_reg <= req;
      if (req && wb_we_i && wb_sel_i[0] && wb_adr_i == sep_pkg::REG_CTRL) begin
        ctrl_reg <= wb_dat_i[sep_pkg::CTRL_W-1:0];
      end
      if (req) begin
        wb_dat_o <= 32'h0000_0000;
        unique case (wb_adr_i)
          sep_pkg::REG_CTRL:   wb_dat_o[sep_pkg::CTRL_W-1:0] <= ctrl_reg;
          sep_pkg::REG_DATA:   wb_dat_o[7:0] <= rx_reg;
          sep_pkg::REG_STATUS: wb_dat_o[sep_pkg::STAT_BUSY] <= xbusy_reg;
          default:             wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign wb_ack_o = ack_reg;

  // ==========================================================================
  // Serial engine: low half drives si, high half ends with a sample
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      so_s1_reg <= 1'b0;
      so_s2_reg <= 1'b0;
    end else begin
      so_s1_reg <= spi.so;
      so_s2_reg <= so_s1_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xbusy_reg <= 1'b0;
      sck_reg   <= 1'b0;
      si_reg    <= 1'b0;
      hi_reg    <= 1'b0;
      bitn_reg  <= 3'h0;
      cnt_reg   <= '0;
      tx_sh_reg <= 8'h00;
      rx_reg    <= 8'h00;
    end else if (start) begin
      xbusy_reg <= 1'b1;
      sck_reg   <= 1'b0;
      si_reg    <= wb_dat_i[7];
      tx_sh_reg <= {wb_dat_i[6:0], 1'b0};
      hi_reg    <= 1'b0;
      bitn_reg  <= 3'h0;
      cnt_reg   <= '0;
    end else if (!xbusy_reg) begin
      sck_reg <= ctrl_reg[sep_pkg::CTRL_CPOL];
    end else if (!ctrl_reg[sep_pkg::CTRL_PAUSE] && !pause_wr) begin
      if (cnt_reg != CNT_W'(SCK_HALF - 1)) begin
        cnt_reg <= cnt_reg + CNT_W'(1);
      end else begin
        cnt_reg <= '0;
        if (!hi_reg) begin
          sck_reg <= 1'b1;
          hi_reg  <= 1'b1;
        end else begin
          rx_reg <= {rx_reg[6:0], so_s2_reg};
          hi_reg <= 1'b0;
          if (bitn_reg == sep_pkg::BIT_LAST) begin
            xbusy_reg <= 1'b0;
            sck_reg   <= ctrl_reg[sep_pkg::CTRL_CPOL];
          end else begin
            sck_reg   <= 1'b0;
            si_reg    <= tx_sh_reg[7];
            tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
            bitn_reg  <= bitn_reg + 3'h1;
          end
        end
      end
    end
  end

  assign spi.cs_n   = ~ctrl_reg[sep_pkg::CTRL_SEL];
  assign spi.hold_n = ~(ctrl_reg[sep_pkg::CTRL_PAUSE] &
                        ctrl_reg[sep_pkg::CTRL_SEL]);
  assign spi.wp_n   = ~ctrl_reg[sep_pkg::CTRL_WP];
  assign spi.sck    = sck_reg;
  assign spi.si     = si_reg;

endmodule : sep_host
`default_nettype wire

//--- tb/sep_spi_assertions.sv
// Checker on the host-device serial link and the device busy level.
// Assumes the bench clock and reset; instantiated beside the link.
`timescale 1ns/100ps
`default_nettype none
module sep_spi_assertions #(
  parameter int PROG_CYCLES = 200  // Write cycle length
) (
  input wire logic clk_i,   // System clock
  input wire logic rst_i,   // Sync reset, high
  input wire logic cs_n,    // Select, low active
  input wire logic sck,     // Serial clock
  input wire logic si,      // Host data out
  input wire logic so,      // Device data out
  input wire logic so_oe,   // Device drives so
  input wire logic hold_n,  // Pause, low active
  input wire logic wp_n,    // Write protect, low active
  input wire logic busy_o   // Write cycle running
);
  // ==========================================================================
  // Busy length counter
  int busy_len;
  always_ff @(posedge clk_i) begin
    if (rst_i || !busy_o) begin
      busy_len <= 0;
    end else begin
      busy_len <= busy_len + 1;
    end
  end
  // ==========================================================================
  // Properties
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  property p_desel;
    cs_n [*4] |-> !so_oe;
  endproperty
  a_desel: assert property (p_desel)
    else $error("so driven while deselected");
  property p_hold;
    !hold_n [*4] |-> !so_oe;
  endproperty
  a_hold: assert property (p_hold)
    else $error("so driven while paused");
  property p_so_fall;
    so_oe && $past(so_oe) && $changed(so) |->
      !sck && !$past(sck) && !$past(sck, 2);
  endproperty
  a_so_fall: assert property (p_so_fall)
    else $error("so changed away from a falling clock edge");
  property p_busy_len;
    $fell(busy_o) |-> busy_len == PROG_CYCLES;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("write cycle length wrong");
  property p_busy_max;
    busy_o |-> busy_len < PROG_CYCLES;
  endproperty
  a_busy_max: assert property (p_busy_max)
    else $error("write cycle overran");
  property p_busy_start;
    $rose(busy_o) |-> cs_n && $past(cs_n);
  endproperty
  a_busy_start: assert property (p_busy_start)
    else $error("write cycle started while selected");
  property p_busy_keep;
    $rose(busy_o) |-> busy_o [*8];
  endproperty
  a_busy_keep: assert property (p_busy_keep)
    else $error("write cycle cut short");
  property p_oe_sel;
    $rose(so_oe) |-> !cs_n && hold_n && !$past(cs_n, 4);
  endproperty
  a_oe_sel: assert property (p_oe_sel)
    else $error("so enabled without active select");
  property p_si_low;
    $changed(si) |-> !sck;
  endproperty
  a_si_low: assert property (p_si_low)
    else $error("si changed while clock high");
  c_oe: cover property ($rose(so_oe));
  c_busy: cover property ($fell(busy_o));
  c_pause: cover property (!hold_n && !cs_n);
endmodule : sep_spi_assertions
`default_nettype wire

//--- tb/serial_eeprom_pin_ecc_logic_tb.sv
// Bench joining host controller and device over the serial link.
// Assumes the design package, link interface and both ends compiled first.
`timescale 1ns/100ps
`default_nettype none
module serial_eeprom_pin_ecc_logic_tb;
  typedef struct packed {
    logic [15:0] adr;
    logic [7:0]  dat;
    logic        cpol;
  } sep_row_type;
  localparam int PROG = 2000;
  logic        clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, busy, cpol_v;
  logic [7:0]  wb_adr, s, r;
  logic [3:0]  wb_sel;
  logic [31:0] wb_dwr, wb_drd, q;
  int          error_cnt, comparisons, n;
  logic [7:0]  shadow [int];
  sep_row_type rows [4] = '{'{16'h0040, 8'h5A, 1'b0},
    '{16'h0042, 8'hA5, 1'b1}, '{16'h0043, 8'h3C, 1'b0},
    '{16'h7FFF, 8'h81, 1'b1}};
  sep_spi_if spi_bus ();
  sep_host i_sep_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_dwr), .wb_dat_o(wb_drd),
    .wb_ack_o(wb_ack), .spi(spi_bus));
  sep_device #(.PROG_CYCLES(PROG)) i_sep_device (.clk_i(clk_i),
    .rst_i(rst_i), .spi(spi_bus), .busy_o(busy));
  sep_spi_assertions #(.PROG_CYCLES(PROG)) i_sep_spi_assertions (
    .clk_i(clk_i), .rst_i(rst_i), .cs_n(spi_bus.cs_n), .sck(spi_bus.sck),
    .si(spi_bus.si), .so(spi_bus.so), .so_oe(spi_bus.so_oe),
    .hold_n(spi_bus.hold_n), .wp_n(spi_bus.wp_n), .busy_o(busy));
  // ==========================================================================
  // Tasks
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_sel <= 4'hF;
    wb_adr <= a;
    wb_dwr <= d;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack !== 1'b1 && k < 50);
    q = wb_drd;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (k >= 50) error_cnt++;
  endtask : wb
  task fin(output logic [7:0] b);
    int k;
    k = 0;
    do begin
      wb(1'b0, sep_pkg::REG_STATUS, 32'h0);
      k++;
    end while (q[sep_pkg::STAT_BUSY] !== 1'b0 && k < 60);
    wb(1'b0, sep_pkg::REG_DATA, 32'h0);
    b = q[7:0];
  endtask : fin
  task xfer(input logic [7:0] b);
    wb(1'b1, sep_pkg::REG_DATA, {24'h0, b});
    fin(r);
  endtask : xfer
  task ctl(input logic sl, input logic p);
    wb(1'b1, sep_pkg::REG_CTRL, {28'h0, cpol_v, 1'b0, p, sl});
  endtask : ctl
  task open_frame;
    ctl(1'b0, 1'b0);
    ctl(1'b1, 1'b0);
  endtask : open_frame
  task rdsr;
    open_frame();
    xfer(sep_pkg::OP_RDSR);
    xfer(8'h00);
    s = r;
    ctl(1'b0, 1'b0);
  endtask : rdsr
  task write_enable;
    open_frame();
    xfer(sep_pkg::OP_WREN);
    ctl(1'b0, 1'b0);
  endtask : write_enable
  task wait_idle;
    n = 0;
    do begin
      rdsr();
      n++;
    end while (s[sep_pkg::SR_BUSY] !== 1'b0 && n < 20);
  endtask : wait_idle
  function automatic logic [7:0] exp_byte(input int a);
    return shadow.exists(a) ? shadow[a] : 8'hFF;
  endfunction : exp_byte
  task rd_group(input logic [15:0] a);
    logic [15:0] b;
    b = a & 16'h7FFC;
    open_frame();
    xfer(sep_pkg::OP_READ);
    xfer(b[15:8]);
    xfer(b[7:0]);
    for (int i = 0; i < 4; i++) begin
      xfer(8'h00);
      chk("read byte", {24'h0, exp_byte(b + i)}, {24'h0, r});
    end
    ctl(1'b0, 1'b0);
  endtask : rd_group
  // ==========================================================================
  // Clock, reset, watchdog, tests
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  initial begin
    repeat (60000) @(posedge clk_i);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    {wb_cyc, wb_stb, wb_we, cpol_v} = 4'h0;
    wb_adr = 8'h00;
    wb_dwr = 32'h0;
    wb_sel = 4'h0;
    rst_i = 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rdsr();
    chk("status after reset", 32'h0, {24'h0, s});
    rd_group(16'h0100);
    $display("test reset done");
    foreach (rows[i]) begin
      cpol_v = rows[i].cpol;
      write_enable();
      open_frame();
      xfer(sep_pkg::OP_WRITE);
      xfer(rows[i].adr[15:8]);
      xfer(rows[i].adr[7:0]);
      xfer(rows[i].dat);
      ctl(1'b0, 1'b0);
      shadow[rows[i].adr & 16'h7FFF] = rows[i].dat;
      rdsr();
      chk("busy during write", 32'h1, {31'h0, s[sep_pkg::SR_BUSY]});
      wait_idle();
      chk("status after write", 32'h0, {24'h0, s});
      rd_group(rows[i].adr);
    end
    $display("test table done");
    write_enable();
    open_frame();
    xfer(sep_pkg::OP_WRITE);
    xfer(8'h00);
    xfer(8'h80);
    for (int i = 0; i < 4; i++) begin
      shadow[16'h0080 + i] = 8'hC0 + 8'(i);
      xfer(8'hC0 + 8'(i));
    end
    ctl(1'b0, 1'b0);
    wait_idle();
    chk("status after group write", 32'h0, {24'h0, s});
    rd_group(16'h0080);
    $display("test group write done");
    cpol_v = 1'b0;
    open_frame();
    xfer(sep_pkg::OP_READ);
    xfer(8'h00);
    xfer(8'h40);
    wb(1'b1, sep_pkg::REG_DATA, 32'h0);
    repeat (18) @(posedge clk_i);
    ctl(1'b1, 1'b1);
    repeat (40) @(posedge clk_i);
    chk("so_oe in pause", 32'h0, {31'h0, spi_bus.so_oe});
    ctl(1'b1, 1'b0);
    fin(r);
    chk("byte after pause", {24'h0, exp_byte(16'h0040)}, {24'h0, r});
    ctl(1'b0, 1'b0);
    $display("test pause done");
    open_frame();
    xfer(8'hFF);
    xfer(sep_pkg::OP_RDSR);
    xfer(8'h00);
    chk("so_oe after bad opcode", 32'h0, {31'h0, spi_bus.so_oe});
    ctl(1'b0, 1'b0);
    rdsr();
    chk("status after bad opcode", 32'h0, {24'h0, s});
    repeat (3) @(posedge clk_i);
    chk("so_oe deselected", 32'h0, {31'h0, spi_bus.so_oe});
    $display("test bad opcode done");
    write_enable();
    open_frame();
    xfer(sep_pkg::OP_WRSR);
    xfer(8'h8C);
    ctl(1'b0, 1'b0);
    rdsr();
    chk("busy in status write", 32'h1, {31'h0, s[sep_pkg::SR_BUSY]});
    wait_idle();
    chk("status after status write", 32'h8C, {24'h0, s});
    $display("test status write done");
    tally_and_finish();
  end
endmodule : serial_eeprom_pin_ecc_logic_tb
`default_nettype wire
